// File: core/eli_top.sv
/*
  Two-link E1 line status and interrupt block: live line status, gain and
  jitter readouts, write-one-to-clear event flags, excess-zero counter with
  snapshot, and one interrupt output, all behind a classic Wishbone slave.
  Assumes line inputs synchronous to clock_i, event inputs as one-cycle
  pulses, and a master that holds each request until it sees ack.
*/
// Our own choice: register access over Wishbone.
module eli_top
  import eli_pkg::*;
#(
  parameter int REPORT_TICKS = REPORT_CYCLES
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [10:0]  wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // line side
  input  eli_line_in_t      line_i [NUM_LINKS],
  output logic              irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // w1c update where a new event beats a clear in the same cycle
  function automatic logic [7:0] flag_update(input logic [7:0] old_v,
                                             input logic [7:0] set_v,
                                             input logic [7:0] clr_v,
                                             input logic [7:0] mask_v);
    flag_update = ((old_v & ~clr_v) | set_v) & mask_v;
  endfunction

  // masked write keeps reserved bits at zero
  function automatic logic [7:0] masked_write(input logic [7:0] data_v,
                                              input logic [7:0] mask_v);
    masked_write = data_v & mask_v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        ack_r;
  logic [31:0] dat_r;
  logic        req_new;
  logic        wr_commit;
  logic        rd_commit;
  logic [8:0]  reg_index;
  logic        req_link;
  logic [7:0]  req_local;
  logic [7:0]  wr_byte;
  logic [7:0]  link_rdata [NUM_LINKS];
  logic        link_mapped [NUM_LINKS];
  logic [7:0]  rdata_sel;

  assign reg_index = wb_adr_i[10:2];
  assign req_link  = reg_index[8];
  assign req_local = reg_index[7:0];
  assign req_new   = wb_cyc_i & wb_stb_i & ~ack_r;
  // writes and read side effects land on the edge that ends the cycle
  assign wr_commit = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];
  assign rd_commit = wb_cyc_i & wb_stb_i & ack_r & ~wb_we_i;
  assign wr_byte   = wb_dat_i[7:0];
  assign rdata_sel = link_mapped[req_link] ? link_rdata[req_link] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // one-second report tick shared by both links
  localparam int TICK_W = $clog2(REPORT_TICKS + 1);
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;
  logic              tick_wrap;

  assign tick_wrap = (tick_cnt_r == TICK_W'(REPORT_TICKS - 1));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);
      tick_r     <= tick_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-link register set and event logic
  logic link_pending [NUM_LINKS];

  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
    logic [7:0]  tx_jit_ctrl_r;
    logic [7:0]  rx_jit_ctrl_r;
    logic [7:0]  counter_ctrl_r;
    logic [7:0]  line_irq_en_r;
    logic [7:0]  error_irq_en_r;
    logic [7:0]  edge_select_r;
    logic [7:0]  line_events_r;
    logic [7:0]  error_events_r;
    logic [15:0] exz_count_r;
    logic [15:0] snapshot_r;
    logic        trigger_prev_r;
    logic        driver_fail_prev_r;
    logic        signal_loss_prev_r;
    logic [SPACING_WIDTH-1:0] tx_jit_value;
    logic [SPACING_WIDTH-1:0] rx_jit_value;

    logic        wr_here;
    logic        rd_here;
    logic [7:0]  line_set;
    logic [7:0]  error_set;
    logic [7:0]  line_clr;
    logic [7:0]  error_clr;
    logic        df_rise;
    logic        df_fall;
    logic        los_rise;
    logic        los_fall;
    logic        count_enable;
    logic        count_wrap;
    logic        trigger_rise;
    logic        take_snapshot;
    logic [7:0]  status_byte;
    logic [7:0]  gain_byte;

    assign wr_here = wr_commit & (req_link == 1'(l));
    assign rd_here = rd_commit & (req_link == 1'(l));
    // each link only reacts to accesses addressed to its own copy

    // status edges as seen against last cycle
    assign df_rise  = line_i[l].driver_fail_status & ~driver_fail_prev_r;
    assign df_fall  = ~line_i[l].driver_fail_status & driver_fail_prev_r;
    assign los_rise = line_i[l].signal_loss_status & ~signal_loss_prev_r;
    assign los_fall = ~line_i[l].signal_loss_status & signal_loss_prev_r;

    // edge select widens the trigger to both directions
    always_comb begin
      line_set = 8'h00;
      line_set[BIT_DRIVER_FAIL] = df_rise |
        (edge_select_r[BIT_DRIVER_FAIL] & df_fall);
      line_set[BIT_SIGNAL_LOSS] = los_rise |
        (edge_select_r[BIT_SIGNAL_LOSS] & los_fall);
    end

    // excess-zero counter runs only with the enable code written
    assign count_enable = line_i[l].excess_zero_error &
      (counter_ctrl_r[BIT_EXZ_ENABLE_LO+1:BIT_EXZ_ENABLE_LO] ==
       EXZ_COUNT_ENABLE);
    assign count_wrap   = count_enable & (exz_count_r == 16'hFFFF);

    always_comb begin
      error_set = 8'h00;
      error_set[BIT_TEMPLATE_LIMIT] =
        line_i[l].pulse_template_limit;
      error_set[BIT_TX_FIFO]     = line_i[l].tx_jitter_fifo_error;
      error_set[BIT_RX_FIFO]     = line_i[l].rx_jitter_fifo_error;
      error_set[BIT_EXCESS_ZERO] = line_i[l].excess_zero_error;
      error_set[BIT_CODE_VIOL]   = line_i[l].code_violation;
      error_set[BIT_COUNT_OVF]   = count_wrap;
    end

    // only ones written to a flag clear it, zeros change nothing
    assign line_clr  = (wr_here & (req_local == IDX_LINE_EVENTS)) ?
                       wr_byte : 8'h00;
    assign error_clr = (wr_here & (req_local == IDX_ERROR_EVENTS)) ?
                       wr_byte : 8'h00;

    // snapshot source: one-second tick or trigger rise
    assign trigger_rise  = counter_ctrl_r[BIT_TRANSFER_TRIG] & ~trigger_prev_r;
    assign take_snapshot = counter_ctrl_r[BIT_REPORT_MODE] ?
                           tick_r : trigger_rise;

    //////////////////////////////////////////////////////////////////////////
    // software-written control registers
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        tx_jit_ctrl_r  <= RESET_BYTE;
        rx_jit_ctrl_r  <= RESET_BYTE;
        counter_ctrl_r <= RESET_BYTE;
        line_irq_en_r  <= RESET_BYTE;
        error_irq_en_r <= RESET_BYTE;
        edge_select_r  <= RESET_BYTE;
      end else if (wr_here) begin
        unique case (req_local)
          IDX_TX_JIT_CTRL:  tx_jit_ctrl_r  <= masked_write(wr_byte,
                                                MASK_JIT_CTRL);
          IDX_RX_JIT_CTRL:  rx_jit_ctrl_r  <= masked_write(wr_byte,
                                                MASK_JIT_CTRL);
          IDX_COUNTER_CTRL: counter_ctrl_r <= masked_write(wr_byte,
                                                MASK_COUNTER_CTRL);
          IDX_LINE_IRQ_EN:  line_irq_en_r  <= masked_write(wr_byte,
                                                MASK_LINE_BITS);
          IDX_ERROR_IRQ_EN: error_irq_en_r <= masked_write(wr_byte,
                                                MASK_ERROR_BITS);
          IDX_EDGE_SELECT:  edge_select_r  <= masked_write(wr_byte,
                                                MASK_LINE_BITS);
          default: ;                             // other indices hold no state
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // sticky event flags and edge history
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        line_events_r      <= RESET_BYTE;
        error_events_r     <= RESET_BYTE;
        driver_fail_prev_r <= 1'b0;
        signal_loss_prev_r <= 1'b0;
      end else begin
        line_events_r  <= flag_update(line_events_r, line_set, line_clr,
                                      MASK_LINE_BITS);
        error_events_r <= flag_update(error_events_r, error_set, error_clr,
                                      MASK_ERROR_BITS);
        driver_fail_prev_r <= line_i[l].driver_fail_status;
        signal_loss_prev_r <= line_i[l].signal_loss_status;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // excess-zero counter and its snapshot; counter is never reset by a copy
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        exz_count_r    <= RESET_COUNT;
        snapshot_r     <= RESET_COUNT;
        trigger_prev_r <= 1'b0;
      end else begin
        if (count_enable) begin
          exz_count_r <= exz_count_r + 16'h0001;
        end
        if (take_snapshot) begin
          snapshot_r <= exz_count_r;
        end
        trigger_prev_r <= counter_ctrl_r[BIT_TRANSFER_TRIG];
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // jitter readouts
    eli_jitter_meas #(
      .WIDTH (SPACING_WIDTH)
    ) u_tx_jit (
      .clock_i    (clock_i),
      .reset_i    (reset_i),
      .peak_sel_i (tx_jit_ctrl_r[BIT_PEAK_SELECT]),
      .spacing_i  (line_i[l].tx_pointer_spacing),
      .clear_i    (wr_here & (req_local == IDX_TX_JIT_MEAS) &
                   (|wr_byte)),
      .read_i     (rd_here & (req_local == IDX_TX_JIT_MEAS)),
      .value_o    (tx_jit_value)
    );

    eli_jitter_meas #(
      .WIDTH (SPACING_WIDTH)
    ) u_rx_jit (
      .clock_i    (clock_i),
      .reset_i    (reset_i),
      .peak_sel_i (rx_jit_ctrl_r[BIT_PEAK_SELECT]),
      .spacing_i  (line_i[l].rx_pointer_spacing),
      .clear_i    (wr_here & (req_local == IDX_RX_JIT_MEAS) &
                   (|wr_byte)),
      .read_i     (rd_here & (req_local == IDX_RX_JIT_MEAS)),
      .value_o    (rx_jit_value)
    );

    //////////////////////////////////////////////////////////////////////////
    // read path of this link
    always_comb begin
      status_byte = 8'h00;
      status_byte[BIT_DRIVER_FAIL] = line_i[l].driver_fail_status;
      status_byte[BIT_SIGNAL_LOSS] = line_i[l].signal_loss_status;
    end
    // gain codes above 10101 all stand for the top band
    assign gain_byte = {3'h0, line_i[l].receive_gain_code};

    always_comb begin
      link_mapped[l] = 1'b1;
      unique case (req_local)
        IDX_TX_JIT_CTRL:  link_rdata[l] = tx_jit_ctrl_r;
        IDX_RX_JIT_CTRL:  link_rdata[l] = rx_jit_ctrl_r;
        IDX_COUNTER_CTRL: link_rdata[l] = counter_ctrl_r;
        IDX_LINE_IRQ_EN:  link_rdata[l] = line_irq_en_r;
        IDX_ERROR_IRQ_EN: link_rdata[l] = error_irq_en_r;
        IDX_EDGE_SELECT:  link_rdata[l] = edge_select_r;
        IDX_LINE_STATUS:  link_rdata[l] = status_byte;
        IDX_RX_GAIN:      link_rdata[l] = gain_byte;
        IDX_TX_JIT_MEAS:  link_rdata[l] = {1'b0, tx_jit_value};
        IDX_RX_JIT_MEAS:  link_rdata[l] = {1'b0, rx_jit_value};
        IDX_LINE_EVENTS:  link_rdata[l] = line_events_r;
        IDX_ERROR_EVENTS: link_rdata[l] = error_events_r;
        IDX_COUNT_HIGH:   link_rdata[l] = snapshot_r[15:8];
        IDX_COUNT_LOW:    link_rdata[l] = snapshot_r[7:0];
        default: begin
          link_rdata[l]  = 8'h00;
          link_mapped[l] = 1'b0;
        end
      endcase
    end

    // enabled flags of this link
    assign link_pending[l] =
      (|(line_events_r & line_irq_en_r)) |
      (|(error_events_r & error_irq_en_r));
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output, level while any enabled flag stays set
  logic irq_r;
  logic irq_nxt;

  assign irq_nxt = link_pending[0] | link_pending[1];

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after the strobe, data latched with it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req_new;
      if (req_new) begin
        dat_r <= {24'h00_0000, rdata_sel};
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o    = irq_r;

endmodule

// File: core/eli_pkg.sv
/*
  Constants, register map and carrier types for the E1 line status and
  interrupt block: register indices, bit positions, write masks, reset
  values and the report timing.
  Assumes a 40 MHz system clock and a word-wide Wishbone slave where each
  register index occupies one aligned 32-bit word (byte address = 4*index).
*/
package eli_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices within one link (byte address is four times these)
  localparam logic [7:0] IDX_TX_JIT_CTRL   = 8'h21;
  localparam logic [7:0] IDX_RX_JIT_CTRL   = 8'h27;
  localparam logic [7:0] IDX_COUNTER_CTRL  = 8'h31;
  localparam logic [7:0] IDX_LINE_IRQ_EN   = 8'h33;
  localparam logic [7:0] IDX_ERROR_IRQ_EN  = 8'h34;
  localparam logic [7:0] IDX_EDGE_SELECT   = 8'h35;
  localparam logic [7:0] IDX_LINE_STATUS   = 8'h36;
  localparam logic [7:0] IDX_RX_GAIN       = 8'h37;
  localparam logic [7:0] IDX_TX_JIT_MEAS   = 8'h38;
  localparam logic [7:0] IDX_RX_JIT_MEAS   = 8'h39;
  localparam logic [7:0] IDX_LINE_EVENTS   = 8'h3A;
  localparam logic [7:0] IDX_ERROR_EVENTS  = 8'h3B;
  localparam logic [7:0] IDX_COUNT_HIGH    = 8'h3C;
  localparam logic [7:0] IDX_COUNT_LOW     = 8'h3D;
  // second link copy offset, carried by index bit 8
  localparam logic [8:0] IDX_LINK_STRIDE   = 9'h100;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions
  localparam int BIT_DRIVER_FAIL    = 2;
  localparam int BIT_SIGNAL_LOSS    = 0;
  localparam int BIT_TEMPLATE_LIMIT = 6;
  localparam int BIT_TX_FIFO        = 5;
  localparam int BIT_RX_FIFO        = 4;
  localparam int BIT_EXCESS_ZERO    = 2;
  localparam int BIT_CODE_VIOL      = 1;
  localparam int BIT_COUNT_OVF      = 0;
  localparam int BIT_PEAK_SELECT    = 5;
  localparam int BIT_REPORT_MODE    = 1;
  localparam int BIT_TRANSFER_TRIG  = 0;
  localparam int BIT_EXZ_ENABLE_LO  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // writable and readable bit masks, reset values
  localparam logic [7:0] MASK_LINE_BITS    = 8'h05;
  localparam logic [7:0] MASK_ERROR_BITS   = 8'h77;
  localparam logic [7:0] MASK_COUNTER_CTRL = 8'h5F;
  localparam logic [7:0] MASK_JIT_CTRL     = 8'h20;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [15:0] RESET_COUNT      = 16'h0000;
  localparam logic [1:0] EXZ_COUNT_ENABLE  = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_HZ          = 40000000;
  localparam int REPORT_PERIOD_MS  = 1000;
  localparam int REPORT_CYCLES     = (CLOCK_HZ / 1000) * REPORT_PERIOD_MS;

  localparam int NUM_LINKS     = 2;
  localparam int SPACING_WIDTH = 7;
  localparam int GAIN_WIDTH    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // line-side inputs of one link
  typedef struct packed {
    logic                     driver_fail_status;
    logic                     signal_loss_status;
    logic [GAIN_WIDTH-1:0]    receive_gain_code;
    logic [SPACING_WIDTH-1:0] tx_pointer_spacing;
    logic [SPACING_WIDTH-1:0] rx_pointer_spacing;
    logic                     pulse_template_limit;
    logic                     tx_jitter_fifo_error;
    logic                     rx_jitter_fifo_error;
    logic                     excess_zero_error;
    logic                     code_violation;
  } eli_line_in_t;

endpackage

// File: core/eli_jitter_meas.sv
/*
  Jitter readout for one jitter-attenuator FIFO: present pointer spacing
  or peak-to-peak spacing since the last read.
  Assumes spacing arrives synchronous to clock_i and that read and clear
  are one-cycle pulses from the register slave.
*/
module eli_jitter_meas
  import eli_pkg::*;
#(
  parameter int WIDTH = SPACING_WIDTH
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             peak_sel_i,
  input  wire logic [WIDTH-1:0] spacing_i,
  input  wire logic             clear_i,
  input  wire logic             read_i,
  output logic      [WIDTH-1:0] value_o
);

  logic [WIDTH-1:0] min_r;
  logic [WIDTH-1:0] max_r;
  logic [WIDTH-1:0] value_r;
  logic [WIDTH-1:0] min_nxt;
  logic [WIDTH-1:0] max_nxt;
  logic [WIDTH-1:0] value_nxt;
  logic             restart;

  ////////////////////////////////////////////////////////////////////////////
  // window restarts on read, clear or while in live mode
  assign restart   = clear_i | read_i | ~peak_sel_i;
  assign min_nxt   = restart ? spacing_i :
                     ((spacing_i < min_r) ? spacing_i : min_r);
  assign max_nxt   = restart ? spacing_i :
                     ((spacing_i > max_r) ? spacing_i : max_r);
  // the read returns the value latched a cycle earlier, so the request-cycle sample is lost to this restart
  assign value_nxt = clear_i     ? '0 :
                     ~peak_sel_i ? spacing_i :
                     (max_nxt - min_nxt);

  ////////////////////////////////////////////////////////////////////////////
  // window and readout registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      min_r   <= '0;
      max_r   <= '0;
      value_r <= '0;
    end else begin
      min_r   <= min_nxt;
      max_r   <= max_nxt;
      value_r <= value_nxt;
    end
  end

  assign value_o = value_r;

endmodule

// File: core/_unused_placeholder_never.sv
/*
  Intentionally empty compilation unit kept out of the design.
  Assumes nothing.
*/

// File: test/eli_top_assertions.sv
/*
  Port checker for eli_top: bus answer, live readouts, irq cause.
  Assumes one clock and the synchronous reset of eli_top.
*/
module eli_chk
  import eli_pkg::*;
#(
  parameter int REPORT_TICKS = REPORT_CYCLES
) (
  input wire logic         clock_i,
  input wire logic         reset_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [10:0]  wb_adr_i,
  input wire logic [3:0]   wb_sel_i,
  input wire logic [31:0]  wb_dat_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  input wire eli_line_in_t line_i [NUM_LINKS],
  input wire logic         irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  // status edge history mirrors the block, so a flag cause is visible
  logic [3:0] st_q;
  wire  [3:0] st_w = {line_i[1].driver_fail_status,
    line_i[1].signal_loss_status, line_i[0].driver_fail_status,
    line_i[0].signal_loss_status};
  wire        ev_w = (st_w != st_q) | (|line_i[0][4:0]) | (|line_i[1][4:0]);
  wire        wr_w = wb_ack_o && wb_we_i;
  wire        rd_w = wb_ack_o && !wb_we_i;
  wire  [8:0] ix_w = wb_adr_i[10:2];
  always_ff @(posedge clock_i) st_q <= reset_i ? 4'h0 : st_w;
  ////////////////////////////////////////
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data not zero");
  AST_UNMAPPED: assert property (
    rd_w && ix_w[7:0] > IDX_COUNT_LOW |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (
    rd_w && ix_w[7:0] == IDX_LINE_STATUS |-> wb_dat_o == {29'h0,
    $past(line_i[ix_w[8]].driver_fail_status), 1'b0,
    $past(line_i[ix_w[8]].signal_loss_status)}) else $error("status wrong");
  AST_GAIN: assert property (
    rd_w && ix_w[7:0] == IDX_RX_GAIN |-> wb_dat_o ==
    {27'h0, $past(line_i[ix_w[8]].receive_gain_code)}) else $error("gain");
  AST_IRQ_RISE: assert property (
    $rose(irq_o) && !$past(reset_i) |-> $past(ev_w) || $past(ev_w, 2)
    || $past(wr_w) || $past(wr_w, 2)) else $error("irq rose without cause");
  AST_IRQ_FALL: assert property (
    $fell(irq_o) && !$past(reset_i) |-> $past(wr_w) || $past(wr_w, 2))
    else $error("irq fell without write");
  // main scenarios reached
  cover property ($rose(irq_o));
  cover property (wr_w);
  cover property (rd_w && ix_w[7:0] == IDX_ERROR_EVENTS);
endmodule

bind eli_top eli_chk #(.REPORT_TICKS(REPORT_TICKS)) u_chk (
  .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .line_i(line_i), .irq_o(irq_o));

// File: test/eli_tb_top.sv
/*
  Bench for eli_top: wishbone register sequences with expected values.
  Assumes the checker binds itself; short report period for auto mode.
*/
module eli_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import eli_pkg::*;
  localparam int TICKS = 50;
  logic         clock_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         cyc = 1'b0;
  logic         we = 1'b0;
  logic [10:0]  adr = 11'h0;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdat;
  logic         ack, irq;
  eli_line_in_t li [NUM_LINKS] = '{default: '0};
  int           failures = 0, total_checks = 0;
  int           fb [5] = '{6, 5, 4, 2, 1};
  eli_top #(.REPORT_TICKS(TICKS)) uut (.clock_i(clock_i), .reset_i(reset_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .line_i(li), .irq_o(irq));
  initial forever #12.5 clock_i = ~clock_i;
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one classic cycle; ack and data taken at the same edge
  task automatic acc(input logic w, input logic [8:0] ix,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("Error %0t: no ack", $time);
      end_of_test();
    end
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [8:0] ix, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, ix, 8'h00, q);
    cmp(q, e);
  endtask
  task automatic wr(input logic [8:0] ix, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, ix, d, q);
  endtask
  task automatic pulse(input int p);
    @(posedge clock_i) li[0][p] <= 1'b1;
    @(posedge clock_i) li[0][p] <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int i = 8'h35; i <= 8'h3D; i++) chk(9'(i), 8'h00);
    chk(9'h050, 8'h00);
    @(posedge clock_i) li[1].driver_fail_status <= 1'b1;
    li[1].receive_gain_code <= 5'h1F;
    li[1].rx_pointer_spacing <= 7'h2A;
    wr(9'h136, 8'hFF);
    chk(9'h136, 8'h04);
    chk(9'h137, 8'h1F);
    chk(9'h139, 8'h2A);
    chk(9'h036, 8'h00);
    chk(9'h13A, 8'h04);
    wr(9'h13A, 8'h00);
    chk(9'h13A, 8'h04);
    wr(9'h13A, 8'h04);
    chk(9'h13A, 8'h00);
    @(posedge clock_i) li[1].driver_fail_status <= 1'b0;
    chk(9'h13A, 8'h00);
    wr(9'h035, 8'h01);
    @(posedge clock_i) li[0].signal_loss_status <= 1'b1;
    wr(9'h03A, 8'h01);
    @(posedge clock_i) li[0].signal_loss_status <= 1'b0;
    chk(9'h03A, 8'h01);
    // error flags: masked first, then enabled, then cleared
    foreach (fb[i]) begin
      pulse(4 - i);
      chk(9'h03B, 8'h01 << fb[i]);
      cmp({7'h0, irq}, 8'h00);
      wr(9'h034, 8'h01 << fb[i]);
      repeat (2) @(posedge clock_i);
      cmp({7'h0, irq}, 8'h01);
      wr(9'h03B, 8'h01 << fb[i]);
      repeat (2) @(posedge clock_i);
      cmp({7'h0, irq}, 8'h00);
    end
    // hold the error high long enough to wrap and reach 0x0102
    wr(9'h031, 8'h04);
    @(posedge clock_i) li[0][1] <= 1'b1;
    repeat (65794) @(posedge clock_i);
    li[0][1] <= 1'b0;
    chk(9'h03B, 8'h05);
    wr(9'h031, 8'h05);
    chk(9'h03C, 8'h01);
    chk(9'h03D, 8'h02);
    wr(9'h031, 8'h06);
    pulse(1);
    repeat (TICKS + 10) @(posedge clock_i);
    chk(9'h03D, 8'h03);
    // jitter readout, live then peak-to-peak
    @(posedge clock_i) li[0].tx_pointer_spacing <= 7'h15;
    chk(9'h038, 8'h15);
    wr(9'h021, 8'h20);
    @(posedge clock_i) li[0].tx_pointer_spacing <= 7'h10;
    @(posedge clock_i) li[0].tx_pointer_spacing <= 7'h30;
    chk(9'h038, 8'h20);
    // a nonzero peak stands when the clear lands, so a dead clear shows
    @(posedge clock_i) li[0].tx_pointer_spacing <= 7'h05;
    wr(9'h038, 8'h01);
    chk(9'h038, 8'h00);
    // loss flag of link 0 is still set from the edge test above
    wr(9'h033, 8'h01);
    repeat (2) @(posedge clock_i);
    cmp({7'h0, irq}, 8'h01);
    wr(9'h03A, 8'h01);
    repeat (2) @(posedge clock_i);
    cmp({7'h0, irq}, 8'h00);
    end_of_test();
  end
endmodule
